/* flash_stat_pkg.sv */
// Purpose: Shared constants and types of the flash status register logic.
// Assumes: One 40 MHz system clock and an SPI mode 0/3 link clock.
// Notes: Opcodes other than the status-write and reset ones are plain defaults.
package flash_stat_pkg;

	// Command opcodes seen on the serial link.
	localparam logic [7:0] OPC_WRSR1 = 8'h01;
	localparam logic [7:0] OPC_WRSR2 = 8'h31;
	localparam logic [7:0] OPC_RESET = 8'hF0;
	localparam logic [7:0] RESET_CONFIRM = 8'hD0;
	localparam logic [7:0] OPC_RDSR = 8'h05;
	localparam logic [7:0] OPC_WREN = 8'h06;
	localparam logic [7:0] OPC_WRDI = 8'h04;
	localparam logic [7:0] OPC_PROG = 8'h02;
	localparam logic [7:0] OPC_ERASE_4K = 8'h20;
	localparam logic [7:0] OPC_ERASE_32K = 8'h52;
	localparam logic [7:0] OPC_ERASE_64K = 8'hD8;
	localparam logic [7:0] OPC_ERASE_CHIP = 8'h60;
	localparam logic [7:0] OPC_PROTECT = 8'h36;
	localparam logic [7:0] OPC_UNPROTECT = 8'h39;
	localparam logic [7:0] OPC_LOCKDOWN = 8'h33;
	localparam logic [7:0] OPC_FREEZE = 8'h34;
	localparam logic [7:0] OPC_OTP_PROG = 8'h9B;

	// Field positions in the two status bytes.
	localparam int B1_LOCK = 7;
	localparam int B1_EPE = 5;
	localparam int B1_WPP = 4;
	localparam int B1_SWP_LO = 2;
	localparam int B1_WEL = 1;
	localparam int B_BUSY = 0;
	localparam int B2_RESET_CMD_ENABLE = 4;
	localparam int B2_SLE = 3;
	localparam int B2_PS = 2;
	localparam int B2_ES = 1;

	// Protection summary codes; 2'b10 is never produced.
	localparam logic [1:0] SWP_NONE = 2'h0;
	localparam logic [1:0] SWP_SOME = 2'h1;
	localparam logic [1:0] SWP_ALL = 2'h3;

	// Global protect field of a byte-1 write (bits 5:2).
	localparam logic [3:0] GLOBAL_PROT_CODE = 4'hF;
	localparam logic [3:0] GLOBAL_UNPROT_CODE = 4'h0;

	// Byte counts that make a command complete, and the counter ceiling.
	localparam logic [2:0] WRSR_BYTES = 3'h2;
	localparam logic [2:0] RESET_BYTES = 3'h2;
	localparam logic [2:0] ADDR_CMD_BYTES = 3'h4;
	localparam logic [2:0] BC_MAX = 3'h4;

	// Power-up values of the retained bits.
	localparam logic LOCK_RST = 1'b0;
	localparam logic EPE_RST = 1'b0;
	localparam logic WEL_RST = 1'b0;
	localparam logic RESET_CMD_ENABLE_RST = 1'b0;
	localparam logic SLE_RST = 1'b0;

	// Operations handed to the flash core, plus two handled locally.
	typedef enum logic [3:0] {
		OP_NONE, OP_PROGRAM, OP_ERASE, OP_PROTECT, OP_UNPROTECT,
		OP_LOCKDOWN, OP_FREEZE, OP_OTP, OP_GLOBAL_PROT,
		OP_GLOBAL_UNPROT, OP_RESET, OP_WRSR1, OP_WRSR2
	} core_op_t;

	// Command strobe towards the flash core.
	typedef struct packed {
		logic go;
		core_op_t op;
		logic [7:0] arg;
	} core_cmd_t;

	// Report from the flash core, on the system clock.
	typedef struct packed {
		logic busy;
		logic done;
		logic fail;
		logic abort;
		logic prog_susp;
		logic erase_susp;
		logic prot_any;
		logic prot_all;
	} core_report_t;

	// The two status bytes as one word.
	typedef struct packed {
		logic [7:0] one;
		logic [7:0] two;
	} status_pair_t;

endpackage

/* flash_status_register_logic.sv */
// Purpose: Status bytes of a serial flash, their SPI read-out and updates.
// Assumes: Flash core reports on sys_clk_i; SPI link clock is spi_clk_i.
// Notes: Link flag and output logic are reset by chip select high, not the counters; retained bits only by power-up.
`timescale 1ns/1ps
module flash_status_register_logic
	import flash_stat_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	input wire logic spi_clk_i,
	input wire logic cs_n_i,
	input wire logic mosi_i,
	input wire logic wp_n_i,
	input wire core_report_t core_i,
	output logic miso_o,
	output logic miso_oe_o,
	output core_cmd_t cmd_o,
	output status_pair_t stat_o
);

	// Maps an opcode to the operation it asks for.
	function automatic core_op_t op_kind(input logic [7:0] opc);
		core_op_t k;
		k = OP_NONE;
		case (opc)
			OPC_WRSR1: k = OP_WRSR1;
			OPC_WRSR2: k = OP_WRSR2;
			OPC_PROG: k = OP_PROGRAM;
			OPC_ERASE_4K, OPC_ERASE_32K: k = OP_ERASE;
			OPC_ERASE_64K, OPC_ERASE_CHIP: k = OP_ERASE;
			OPC_PROTECT: k = OP_PROTECT;
			OPC_UNPROTECT: k = OP_UNPROTECT;
			OPC_LOCKDOWN: k = OP_LOCKDOWN;
			OPC_FREEZE: k = OP_FREEZE;
			OPC_OTP_PROG: k = OP_OTP;
			default: k = OP_NONE;
		endcase
		return k;
	endfunction

	// Link side, sampled on the rising link clock except the output shifter and byte select.
	logic act_q; // High from the first link edge of a frame.
	logic [2:0] bm_q; // Bit position within the current byte.
	logic [2:0] bc_q; // Whole bytes received, saturating.
	logic [6:0] in_sh_q; // Serial input shifter.
	logic [7:0] op_q; // Opcode of the last frame.
	logic [7:0] dat_q; // First data byte of the last frame.
	logic tgl_m_q; // Publish toggle, first stage.
	logic tgl_s_q; // Publish toggle, second stage.
	logic ack_q; // Acknowledge toggle back to system side.
	status_pair_t copy_q; // Status copy owned by the link side.
	logic [7:0] out_sh_q; // Serial output shifter.
	logic sel_q; // Which status byte goes out next.

	// System side.
	logic cs_m_q;
	logic cs_s_q;
	logic cs_d_q;
	logic wp_m_q;
	logic wp_s_q;
	logic ack_m_q;
	logic ack_s_q;
	status_pair_t pub_q; // Snapshot offered to the link side.
	logic pub_tgl_q;
	logic lock_q;
	logic epe_q;
	logic wel_q;
	logic reset_cmd_enable_q;
	logic sle_q;
	logic frozen_q; // Set once lockdown state is frozen.
	logic pe_pend_q; // A program or erase is outstanding.
	core_cmd_t cmd_d;
	status_pair_t live;
	logic frame_end;
	logic busy;
	logic [1:0] soft_protect_summary;
	logic wel_set;
	logic wel_clr;
	logic lock_d;
	logic reset_cmd_enable_d;
	logic sle_d;
	logic frz_set;

	// Frame-active flag; chip select high clears it at once, so the
	// next frame starts counting bits from its first edge.
	always_ff @(posedge spi_clk_i or posedge cs_n_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			act_q <= 1'b0;
		end else if (cs_n_i) begin
			act_q <= 1'b0;
		end else begin
			act_q <= 1'b1;
		end
	end

	// Bit and byte counters. They are not cleared by chip select, so
	// they still hold the frame's length when the system side looks.
	always_ff @(posedge spi_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			bm_q <= 3'h0;
			bc_q <= 3'h0;
		end else if (!act_q) begin
			bm_q <= 3'h1;
			bc_q <= 3'h0;
		end else begin
			bm_q <= bm_q + 3'h1;
			if (bm_q == 3'h7 && bc_q != BC_MAX) begin
				bc_q <= bc_q + 3'h1;
			end
		end
	end

	// Input shifter and byte capture of opcode and first data byte.
	always_ff @(posedge spi_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			in_sh_q <= 7'h00;
			op_q <= 8'h00;
			dat_q <= 8'h00;
		end else begin
			in_sh_q <= {in_sh_q[5:0], mosi_i};
			if (act_q && bm_q == 3'h7) begin
				if (bc_q == 3'h0) begin
					op_q <= {in_sh_q, mosi_i};
				end else if (bc_q == 3'h1) begin
					dat_q <= {in_sh_q, mosi_i};
				end
			end
		end
	end

	// Status word crossing, link end. The toggle is synchronised and
	// only then is the held snapshot copied, so the copy is stable.
	// Limitation: the copy refreshes only while the link clock runs,
	// so the first byte of a poll may be stale; later bytes are fresh.
	always_ff @(posedge spi_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			tgl_m_q <= 1'b0;
			tgl_s_q <= 1'b0;
			ack_q <= 1'b0;
			copy_q <= '0;
		end else begin
			tgl_m_q <= pub_tgl_q;
			tgl_s_q <= tgl_m_q;
			if (tgl_s_q != ack_q) begin
				copy_q <= pub_q;
				ack_q <= tgl_s_q;
			end
		end
	end

	// Serial output on the falling edge. During a status read a fresh
	// byte is loaded at every byte boundary, alternating byte 1 and 2.
	always_ff @(negedge spi_clk_i or posedge cs_n_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			out_sh_q <= 8'h00;
			sel_q <= 1'b0;
			miso_o <= 1'b0;
			miso_oe_o <= 1'b0;
		end else if (cs_n_i) begin
			// Chip select high releases the data pin.
			out_sh_q <= 8'h00;
			sel_q <= 1'b0;
			miso_o <= 1'b0;
			miso_oe_o <= 1'b0;
		end else if (act_q && bm_q == 3'h0 && bc_q != 3'h0 && op_q == OPC_RDSR) begin
			out_sh_q <= sel_q ? copy_q.two : copy_q.one;
			miso_o <= sel_q ? copy_q.two[7] : copy_q.one[7];
			miso_oe_o <= 1'b1;
			sel_q <= ~sel_q;
		end else begin
			out_sh_q <= {out_sh_q[6:0], 1'b0};
			miso_o <= out_sh_q[6];
		end
	end

	// Pin and acknowledge synchronisers; the first stages feed only the second.
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cs_m_q <= 1'b1;
			cs_s_q <= 1'b1;
			cs_d_q <= 1'b1;
			wp_m_q <= 1'b1;
			wp_s_q <= 1'b1;
			ack_m_q <= 1'b0;
			ack_s_q <= 1'b0;
		end else begin
			cs_m_q <= cs_n_i;
			cs_s_q <= cs_m_q;
			cs_d_q <= cs_s_q;
			wp_m_q <= wp_n_i;
			wp_s_q <= wp_m_q;
			ack_m_q <= ack_q;
			ack_s_q <= ack_m_q;
		end
	end

	// Chip select has risen; link counters and bytes are now idle.
	assign frame_end = cs_s_q && !cs_d_q;

	// A command still in flight to the core counts as busy.
	assign busy = core_i.busy || cmd_o.go;

	// Protection summary; the reserved code cannot appear.
	assign soft_protect_summary = core_i.prot_all ? SWP_ALL :
		(core_i.prot_any ? SWP_SOME : SWP_NONE);

	// Live status bytes in their documented layout.
	always_comb begin
		live = '0;
		live.one[B1_LOCK] = lock_q;
		live.one[B1_EPE] = epe_q;
		live.one[B1_WPP] = wp_s_q;
		live.one[B1_SWP_LO +: 2] = soft_protect_summary;
		live.one[B1_WEL] = wel_q;
		live.one[B_BUSY] = busy;
		live.two[B2_RESET_CMD_ENABLE] = reset_cmd_enable_q;
		live.two[B2_SLE] = sle_q;
		live.two[B2_PS] = core_i.prog_susp;
		live.two[B2_ES] = core_i.erase_susp;
		live.two[B_BUSY] = busy;
	end

	// Status word crossing, system end. A new snapshot is offered only
	// after the link side acknowledged the previous one.
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			pub_q <= '0;
			pub_tgl_q <= 1'b0;
		end else if (ack_s_q == pub_tgl_q && live != pub_q) begin
			pub_q <= live;
			pub_tgl_q <= ~pub_tgl_q;
		end
	end

	// Command decode at the end of each frame.
	always_comb begin
		core_op_t k;
		logic whole;
		logic need_addr;
		k = op_kind(op_q);
		whole = (bm_q == 3'h0);
		need_addr = (k != OP_WRSR1) && (k != OP_WRSR2);
		cmd_d = '0;
		wel_set = 1'b0;
		wel_clr = 1'b0;
		lock_d = lock_q;
		reset_cmd_enable_d = reset_cmd_enable_q;
		sle_d = sle_q;
		frz_set = 1'b0;
		// Frames of one to seven link edges do nothing; a frame with no edges reuses the last frame's counts and bytes.
		if (frame_end && bc_q != 3'h0) begin
			// The opcode is read only here, where chip select holds the link still.
			cmd_d.arg = op_q;
			case (op_q)
				OPC_WREN: begin
					wel_set = whole && !busy;
				end
				OPC_WRDI: begin
					wel_clr = whole;
				end
				OPC_RESET: begin
					// Runs regardless of the latch; needs the enable.
					if (whole && bc_q >= RESET_BYTES && dat_q == RESET_CONFIRM && reset_cmd_enable_q) begin
						cmd_d.go = 1'b1;
						cmd_d.op = OP_RESET;
						wel_clr = 1'b1;
					end
				end
				default: begin
					if (k == OP_NONE || !wel_q || busy) begin
						// Unknown opcode, latch clear or core busy: the command is rejected.
						wel_clr = 1'b0;
					end else if (!whole || bc_q < (need_addr ? ADDR_CMD_BYTES : WRSR_BYTES)) begin
						// Whole opcode seen but frame cut short.
						wel_clr = 1'b1;
					end else begin
						case (k)
							OP_WRSR1: begin
								wel_clr = 1'b1;
								// Clearing the lock is refused while the pin is low.
								if (wp_s_q || !lock_q || dat_q[B1_LOCK]) begin
									lock_d = dat_q[B1_LOCK];
									if (!lock_q && dat_q[5:2] == GLOBAL_PROT_CODE) begin
										cmd_d.go = 1'b1;
										cmd_d.op = OP_GLOBAL_PROT;
									end else if (!lock_q && dat_q[5:2] == GLOBAL_UNPROT_CODE) begin
										cmd_d.go = 1'b1;
										cmd_d.op = OP_GLOBAL_UNPROT;
									end
								end
							end
							OP_WRSR2: begin
								wel_clr = 1'b1;
								reset_cmd_enable_d = dat_q[B2_RESET_CMD_ENABLE];
								if (!frozen_q) begin
									sle_d = dat_q[B2_SLE];
								end
							end
							OP_PROTECT, OP_UNPROTECT: begin
								if (lock_q) begin
									wel_clr = 1'b1;
								end else begin
									cmd_d.go = 1'b1;
									cmd_d.op = k;
								end
							end
							OP_LOCKDOWN, OP_FREEZE: begin
								if (!sle_q) begin
									wel_clr = 1'b1;
								end else begin
									cmd_d.go = 1'b1;
									cmd_d.op = k;
									frz_set = (k == OP_FREEZE);
								end
							end
							default: begin
								cmd_d.go = 1'b1;
								cmd_d.op = k;
							end
						endcase
					end
				end
			endcase
		end
	end

	// Lock, reset enable and lockdown enable: only status writes move
	// them, except that a Freeze clears lockdown enable for good; a
	// Reset command leaves them untouched.
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			lock_q <= LOCK_RST;
			reset_cmd_enable_q <= RESET_CMD_ENABLE_RST;
			sle_q <= SLE_RST;
			frozen_q <= 1'b0;
		end else begin
			lock_q <= lock_d;
			reset_cmd_enable_q <= reset_cmd_enable_d;
			if (frz_set || frozen_q) begin
				sle_q <= 1'b0;
				frozen_q <= 1'b1;
			end else begin
				sle_q <= sle_d;
			end
		end
	end

	// Write enable latch. Core completions and aborts, including hold
	// aborts, clear it; a Write Enable in the same cycle still wins.
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			wel_q <= WEL_RST;
		end else if (wel_set) begin
			wel_q <= 1'b1;
		end else if (wel_clr || core_i.done || core_i.abort) begin
			wel_q <= 1'b0;
		end
	end

	// Error flag: rewritten by every finished program or erase, kept
	// as it is when the operation aborts.
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			epe_q <= EPE_RST;
			pe_pend_q <= 1'b0;
		end else begin
			if (cmd_d.go && (cmd_d.op == OP_PROGRAM || cmd_d.op == OP_ERASE)) begin
				pe_pend_q <= 1'b1;
			end else if (core_i.done || core_i.abort) begin
				pe_pend_q <= 1'b0;
			end
			if (pe_pend_q && core_i.done) begin
				epe_q <= core_i.fail;
			end
		end
	end

	// Registered outputs to the core and the status view.
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cmd_o <= '0;
			stat_o <= '0;
		end else begin
			cmd_o <= cmd_d;
			stat_o <= live;
		end
	end

endmodule

/* spi_host_model.sv */
// Purpose: Behavioural SPI host that frames commands and reads status bytes.
// Assumes: Mode 0; the 12 ns link clock runs inside frames, apart from one lone nudge during reset.
// Notes: A released data line shows the inverse of its last bit.
`timescale 1ns/1ps
module spi_host_model (
	output logic spi_clk_o,
	output logic cs_n_o,
	output logic mosi_o,
	input wire logic miso_i,
	input wire logic miso_oe_i
);
	logic [7:0] rx_q[$];	// Bytes read back in the last frame.
	logic [7:0] sh;	// Read shifter; an undriven line shifts in unknowns.
	initial begin
		spi_clk_o = 1'b0;
		cs_n_o = 1'b1;
		mosi_o = 1'b0;
	end
	// One link clock; data is set half a period ahead of the rising edge.
	task automatic clk_bit(input logic d);
		mosi_o = d;
		#6 spi_clk_o = 1'b1;
		sh = {sh[6:0], miso_oe_i ? miso_i : 1'bx};
		#6 spi_clk_o = 1'b0;
	endtask
	// A lone clock with no frame, so link flops see an edge in reset.
	task automatic nudge();
		#6 spi_clk_o = 1'b1;
		#6 spi_clk_o = 1'b0;
	endtask
	// Sends the bytes less cut bits, then reads rd bytes; rd below 0 polls.
	task automatic frame(input logic [7:0] q[$], input int cut, input int rd);
		int i;
		rx_q.delete();
		cs_n_o = 1'b0;
		#5;
		for (i = 0; i < q.size() * 8 - cut; i++) begin
			clk_bit(q[i / 8][7 - i % 8]);
		end
		for (i = 0; i < (rd < 0 ? 512 : rd * 8); i++) begin
			clk_bit(~mosi_o);
			if (i % 8 == 7) begin
				rx_q.push_back(sh);
				// Early bytes may be stale, so only a fresh byte one ends a poll.
				if (rd < 0 && i > 16 && i % 16 == 7 && sh[0] === 1'b0) break;
			end
		end
		#6 cs_n_o = 1'b1;
		mosi_o = ~mosi_o;
	endtask
endmodule

/* flash_stat_chk.sv */
// Purpose: Concurrent checks on the ports of the flash status logic.
// Assumes: All checks run on the system clock and rest during reset.
// Notes: Status outputs lag their causes by one to three system cycles.
`timescale 1ns/1ps
module flash_stat_chk
	import flash_stat_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	input wire logic spi_clk_i,
	input wire logic cs_n_i,
	input wire logic mosi_i,
	input wire logic wp_n_i,
	input wire core_report_t core_i,
	input wire logic miso_o,
	input wire logic miso_oe_o,
	input wire core_cmd_t cmd_o,
	input wire status_pair_t stat_o
);
	logic gated_go;	// Go for a program or erase.
	logic prot_go;	// Go that touches sector protection.
	assign gated_go = cmd_o.go && (cmd_o.op == OP_PROGRAM || cmd_o.op == OP_ERASE);
	assign prot_go = cmd_o.go && (cmd_o.op == OP_PROTECT || cmd_o.op == OP_UNPROTECT
		|| cmd_o.op == OP_GLOBAL_PROT || cmd_o.op == OP_GLOBAL_UNPROT);
	default clocking dc @(posedge sys_clk_i);
	endclocking
	default disable iff (sys_rst_i);
	a_busy_follow: assert property (core_i.busy |=> stat_o.one[B_BUSY])
		else $error("busy flag low while core busy");
	a_susp_follow: assert property (
		stat_o.two[B2_PS:B2_ES] == $past({core_i.prog_susp, core_i.erase_susp}))
		else $error("suspend flags do not follow core");
	a_pin_high: assert property (wp_n_i [*5] |-> stat_o.one[B1_WPP])
		else $error("pin state bit low with pin high");
	a_lock_wp: assert property ($fell(stat_o.one[B1_LOCK]) |-> $past(stat_o.one[B1_WPP]))
		else $error("lock cleared while pin asserted");
	a_enable_wel: assert property (
		$rose(stat_o.two[B2_RESET_CMD_ENABLE]) || $rose(stat_o.two[B2_SLE]) |-> $past(stat_o.one[B1_WEL]))
		else $error("byte two enable set without write latch");
	a_epe_done: assert property ($changed(stat_o.one[B1_EPE]) |->
		$past(core_i.done) || $past(core_i.done, 2) || $past(core_i.done, 3))
		else $error("error flag moved without a done");
	a_wel_done: assert property (core_i.done |-> ##[1:3] !stat_o.one[B1_WEL])
		else $error("write latch kept after done");
	a_reset_reset_cmd_enable: assert property (cmd_o.go && cmd_o.op == OP_RESET |-> stat_o.two[B2_RESET_CMD_ENABLE])
		else $error("reset issued while disabled");
	a_lockdown_sle: assert property (
		cmd_o.go && (cmd_o.op == OP_LOCKDOWN || cmd_o.op == OP_FREEZE) |-> $past(stat_o.two[B2_SLE]))
		else $error("lockdown issued while disabled");
	a_prot_lock: assert property (prot_go |-> !$past(stat_o.one[B1_LOCK]))
		else $error("protection changed while locked");
	a_gated_wel: assert property (gated_go |-> $past(stat_o.one[B1_WEL]))
		else $error("program or erase without write latch");
	c_reset: cover property (cmd_o.go && cmd_o.op == OP_RESET);
	c_epe: cover property ($rose(stat_o.one[B1_EPE]));
	c_busy_end: cover property ($fell(stat_o.one[B_BUSY]));
endmodule
bind flash_status_register_logic flash_stat_chk flash_stat_chk_inst (
	.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .spi_clk_i(spi_clk_i), .cs_n_i(cs_n_i),
	.mosi_i(mosi_i), .wp_n_i(wp_n_i), .core_i(core_i), .miso_o(miso_o),
	.miso_oe_o(miso_oe_o), .cmd_o(cmd_o), .stat_o(stat_o)
);

/* test_flash_status_register_logic.sv */
// Purpose: Self-checking bench of the flash status register logic.
// Assumes: The bench plays the flash core; the host model drives the link.
// Notes: Status is judged on stat_o and on bytes read over the link.
`timescale 1ns/1ps
module test_flash_status_register_logic
	import flash_stat_pkg::*;
;
	logic sys_clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic wp_n_i = 1'b1;
	core_report_t core_i = '0;
	wire spi_clk;
	wire cs_n;
	wire mosi;
	logic miso_o;
	logic miso_oe_o;
	core_cmd_t cmd_o;
	status_pair_t stat_o;
	int fail_count = 0;
	int checks_done = 0;
	int go_n = 0;	// Command strobes seen.
	int cyc = 0;
	core_op_t go_op = OP_NONE;	// Operation of the last strobe.
	logic [7:0] go_arg = 8'h00;	// Opcode carried by the last strobe.
	always #12.5 sys_clk_i = ~sys_clk_i;
	spi_host_model spi_host_model_inst (.spi_clk_o(spi_clk), .cs_n_o(cs_n), .mosi_o(mosi),
		.miso_i(miso_o), .miso_oe_i(miso_oe_o));
	flash_status_register_logic flash_status_register_logic_inst (.sys_clk_i(sys_clk_i),
		.sys_rst_i(sys_rst_i), .spi_clk_i(spi_clk), .cs_n_i(cs_n), .mosi_i(mosi),
		.wp_n_i(wp_n_i), .core_i(core_i), .miso_o(miso_o), .miso_oe_o(miso_oe_o),
		.cmd_o(cmd_o), .stat_o(stat_o));
	// Counts strobes so that refused commands show as no strobe at all.
	always @(posedge sys_clk_i) begin
		if (cmd_o.go === 1'b1) begin
			go_n++;
			go_op = cmd_o.op;
			go_arg = cmd_o.arg;
		end
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			give_verdict();
		end
	end
	task automatic give_verdict();
		if (fail_count == 0 && checks_done > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH %s exp %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk_i);
		#2;
	endtask
	// Runs a core operation, ending it as done, failed or aborted.
	task automatic core_run(input logic fl, input logic ab);
		core_i.busy = 1'b1;
		tick(6);
		core_i.busy = 1'b0;
		core_i.done = ~ab;
		core_i.fail = fl;
		core_i.abort = ab;
		tick(1);
		{core_i.done, core_i.fail, core_i.abort} = 3'h0;
		tick(4);
	endtask
	task automatic send(input logic [7:0] q[$], input int cut = 0);
		spi_host_model_inst.frame(q, cut, 0);
		tick(8);
	endtask
	// Reads four bytes; only the last two are taken, the first may be stale.
	task automatic rd_stat(output logic [15:0] st);
		spi_host_model_inst.frame('{OPC_RDSR}, 0, 4);
		st = {spi_host_model_inst.rx_q[2], spi_host_model_inst.rx_q[3]};
		tick(8);
	endtask
	// Write enable, then one command; judges the strobe and finishes the core op.
	task automatic wr(input logic [7:0] q[$], input int n_go, input core_op_t op,
		input logic fl = 1'b0, input logic ab = 1'b0);
		int n0;
		n0 = go_n;
		send('{OPC_WREN});
		send(q);
		check("go count", 16'(go_n - n0), 16'(n_go));
		if (n_go > 0) begin
			check("go op", 16'(go_op), 16'(op));
			check("go arg", 16'(go_arg), 16'(q[0]));
			core_run(fl, ab);
		end
	endtask
	task automatic t_power_up();
		logic [15:0] st;
		rd_stat(st);
		check("read status", st, 16'h1000);
		check("status out", stat_o, 16'h1000);
		send('{OPC_RESET, RESET_CONFIRM});
		check("reset refused", 16'(go_n), 16'h0);
	endtask
	task automatic t_swp();
		logic [1:0] codes [3] = '{SWP_NONE, SWP_SOME, SWP_ALL};
		for (int i = 0; i < 3; i++) begin
			core_i.prot_any = (i > 0);
			core_i.prot_all = (i == 2);
			tick(3);
			check("summary", 16'(stat_o.one[3:2]), 16'(codes[i]));
		end
		{core_i.prot_any, core_i.prot_all} = 2'h0;
		tick(3);
	endtask
	task automatic t_wel();
		send('{OPC_WREN});
		send('{OPC_WRSR1}, 3);
		send('{8'hAA});
		check("latch kept", 16'(stat_o.one[B1_WEL]), 16'h1);
		send('{OPC_WRDI});
		check("latch off", 16'(stat_o.one[B1_WEL]), 16'h0);
		send('{OPC_WREN});
		send('{OPC_WRSR1, 8'h80}, 3);
		check("short write", 16'(stat_o.one), 16'h10);
		send('{OPC_WRSR1, 8'h80});
		send('{OPC_PROG, 8'h00, 8'h10, 8'h00});
		check("no latch", {stat_o.one, 8'(go_n)}, 16'h1000);
	endtask
	task automatic t_lock();
		wr('{OPC_WRSR1, 8'hFF}, 1, OP_GLOBAL_PROT);
		check("lock set", 16'(stat_o.one), 16'h90);
		wp_n_i = 1'b0;
		tick(6);
		check("pin state", 16'(stat_o.one[B1_WPP]), 16'h0);
		wr('{OPC_WRSR1, 8'h00}, 0, OP_NONE);
		check("lock held", 16'(stat_o.one), 16'h80);
		wr('{OPC_WRSR1, 8'hBC}, 0, OP_NONE);
		check("lock kept", 16'(stat_o.one), 16'h80);
		wr('{OPC_PROTECT, 8'h00, 8'h10, 8'h00}, 0, OP_NONE);
		check("latch refused", 16'(stat_o.one[B1_WEL]), 16'h0);
		wp_n_i = 1'b1;
		tick(6);
		wr('{OPC_WRSR1, 8'h00}, 0, OP_NONE);
		check("lock clear", 16'(stat_o.one), 16'h10);
		wr('{OPC_WRSR1, 8'h00}, 1, OP_GLOBAL_UNPROT);
		wr('{OPC_PROTECT, 8'h00, 8'h10, 8'h00}, 1, OP_PROTECT);
		wr('{OPC_UNPROTECT, 8'h00, 8'h10, 8'h00}, 1, OP_UNPROTECT);
	endtask
	task automatic t_epe();
		logic [7:0] opc [6] = '{OPC_PROG, OPC_ERASE_4K, OPC_ERASE_32K, OPC_ERASE_64K,
			OPC_ERASE_CHIP, OPC_OTP_PROG};
		core_op_t eop [6] = '{OP_PROGRAM, OP_ERASE, OP_ERASE, OP_ERASE, OP_ERASE, OP_OTP};
		logic [5:0] fl = 6'h0B;	// The aborted first run reports a fail that must not stick.
		for (int i = 0; i < 6; i++) begin
			wr('{opc[i], 8'h00, 8'h10, 8'h00}, 1, eop[i], fl[i], i == 0);
			check("error flag", {stat_o.one[B1_EPE], stat_o.one[B1_WEL]},
				16'({fl[i] && i != 0, 1'b0}));
		end
	endtask
	task automatic t_busy();
		core_i.busy = 1'b1;
		fork
			spi_host_model_inst.frame('{OPC_RDSR}, 0, -1);
			begin
				tick(40);
				core_i.busy = 1'b0;
			end
		join
		check("busy seen", 16'(spi_host_model_inst.rx_q[2][0]), 16'h1);
		check("busy end", 16'(spi_host_model_inst.rx_q[$][0]), 16'h0);
		tick(8);
	endtask
	task automatic t_susp();
		for (int i = 0; i < 4; i++) begin
			{core_i.prog_susp, core_i.erase_susp} = 2'(i);
			tick(3);
			check("suspend", 16'(stat_o.two), 16'(i * 2));
		end
		{core_i.prog_susp, core_i.erase_susp} = 2'h0;
		tick(3);
	endtask
	task automatic t_byte2();
		wr('{OPC_LOCKDOWN, 8'h00, 8'h10, 8'h00}, 0, OP_NONE);
		wr('{OPC_WRSR2, 8'h18}, 0, OP_NONE);
		wr('{OPC_WRSR1, 8'h84}, 0, OP_NONE);
		send('{OPC_WREN});
		send('{OPC_RESET, RESET_CONFIRM});
		check("reset go", 16'(go_op), 16'(OP_RESET));
		check("after reset", stat_o, 16'h9018);
		wr('{OPC_LOCKDOWN, 8'h00, 8'h10, 8'h00}, 1, OP_LOCKDOWN);
		check("enable kept", 16'(stat_o.two), 16'h18);
		wr('{OPC_FREEZE, 8'h00, 8'h10, 8'h00}, 1, OP_FREEZE);
		wr('{OPC_WRSR2, 8'h18}, 0, OP_NONE);
		check("frozen", 16'(stat_o.two), 16'h10);
	endtask
	initial begin
		spi_host_model_inst.nudge();
		tick(6);
		sys_rst_i = 1'b0;
		tick(4);
		t_power_up();
		t_swp();
		t_wel();
		t_lock();
		t_epe();
		t_busy();
		t_susp();
		t_byte2();
		give_verdict();
	end
endmodule
